// >>> shared/freq_offset_pkg.sv
package freq_offset_pkg;

	localparam int OFFSET_W = 26;
	localparam int LOW_W    = 16;
	localparam int HIGH_W   = 10;
	localparam int RANGE_W  = 4;

	// register indices on the serial link
	localparam logic [7:0] REG_LOW_IDX   = 8'h00;
	localparam logic [7:0] REG_HIGH_IDX  = 8'h01;
	localparam logic [7:0] REG_RANGE_IDX = 8'h02;

	// field positions inside the index 1 register
	localparam int HIGH_MSB   = 9;
	localparam int OE_BIT     = 10;
	localparam int RO_LSB     = 11;

	// reset values
	localparam logic [LOW_W-1:0]    LOW_RST    = 16'h0000;
	localparam logic [HIGH_W-1:0]   HIGH_RST   = 10'h000;
	localparam logic                OE_RST     = 1'b0;
	localparam logic [OFFSET_W-1:0] OFFSET_RST = 26'h0000000;

	// serial byte framing
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [1:0] IDX_PTR       = 2'h0;
	localparam logic [1:0] IDX_HI        = 2'h1;
	localparam logic [1:0] IDX_LO        = 2'h2;

	// open-drain data pin only ever pulls low
	localparam logic SDA_DRIVE_LEVEL = 1'b0;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'h0,
		ST_ADDR  = 3'h1,
		ST_ACK_A = 3'h3,
		ST_RXB   = 3'h2,
		ST_ACK_W = 3'h6,
		ST_TXB   = 3'h7,
		ST_ACK_R = 3'h5
	} link_state_t;

endpackage

// >>> hdl/freq_offset_control_regs.sv
`timescale 1ns/1ps
module freq_offset_control_regs #(
	parameter logic [6:0] DEV_ADDR      = 7'h55, // arbitrary value
	parameter logic [3:0] RANGE_DEFAULT = 4'h9
) (
	input  wire logic                                        clk_in,
	input  wire logic                                        rst_n_in,
	input  wire logic                                        scl_in,
	input  wire logic                                        sda_in,
	output wire logic                                        sda_out,
	output wire logic                                        sda_oe_out,
	input  wire logic                                        oe_sw_ctrl_in,
	input  wire logic                                        oe_pin_in,
	output wire logic                                        output_enable_out,
	output wire logic signed [freq_offset_pkg::OFFSET_W-1:0] freq_offset_word_out,
	output wire logic                                        freq_update_out,
	output wire logic        [freq_offset_pkg::RANGE_W-1:0]  pull_range_out
);
	import freq_offset_pkg::*;

	// reserved general-call and high-speed address groups cannot be served
	if (DEV_ADDR[6:3] == 4'h0 || DEV_ADDR[6:3] == 4'hF) begin : g_addr_chk
		$error("device address falls in a reserved group");
	end

	link_state_t         state_r;
	logic                scl_q_r;
	logic                sda_q_r;
	logic [3:0]          bit_cnt_r;
	logic [7:0]          shift_r;
	logic [7:0]          tx_r;
	logic [7:0]          ptr_r;
	logic [7:0]          hold_r;
	logic [1:0]          byte_idx_r;
	logic                rw_r;
	logic                half_r;
	logic                mack_r;
	logic                sda_oe_r;
	logic [LOW_W-1:0]    low_r;
	logic [HIGH_W-1:0]   high_r;
	logic                oe_bit_r;
	logic [RANGE_W-1:0]  range_r;
	logic [OFFSET_W-1:0] applied_r;
	logic                update_r;
	logic                oe_out_r;

	// read word assembly, unused indices read zero
	function automatic logic [15:0] reg_word(input logic [7:0] idx,
		input logic [LOW_W-1:0] lo, input logic [HIGH_W-1:0] hi,
		input logic oe, input logic [RANGE_W-1:0] rng);
		logic [15:0] w;
		w = 16'h0000;
		case (idx)
			REG_LOW_IDX:   w = lo;
			REG_HIGH_IDX:  w = {5'h00, oe, hi};
			REG_RANGE_IDX: w = {12'h000, rng};
			default:       w = 16'h0000;
		endcase
		return w;
	endfunction

	// bus conditions; pins are already synchronous to clk_in
	wire scl_rise_w   = !scl_q_r && scl_in;
	wire scl_fall_w   = scl_q_r && !scl_in;
	wire start_w      = scl_q_r && scl_in && sda_q_r && !sda_in;
	wire stop_w       = scl_q_r && scl_in && !sda_q_r && sda_in;
	wire byte_full_w  = (bit_cnt_r == BITS_PER_BYTE);
	wire addr_match_w = (shift_r[7:1] == DEV_ADDR);
	wire rx_done_w    = scl_fall_w && (state_r == ST_RXB) && byte_full_w;
	wire wr_commit_w  = rx_done_w && (byte_idx_r == IDX_LO);
	wire [15:0] wdata_w = {hold_r, shift_r};
	wire [15:0] rd_word_w = reg_word(ptr_r, low_r, high_r, oe_bit_r, range_r);
	wire [7:0]  tx_next_w = half_r ? rd_word_w[7:0] : rd_word_w[15:8];
	wire wr_low_w   = wr_commit_w && (ptr_r == REG_LOW_IDX);
	wire wr_high_w  = wr_commit_w && (ptr_r == REG_HIGH_IDX);
	wire wr_range_w = wr_commit_w && (ptr_r == REG_RANGE_IDX);

	// pin edge history
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			scl_q_r <= 1'b1;
			sda_q_r <= 1'b1;
		end else begin
			scl_q_r <= scl_in;
			sda_q_r <= sda_in;
		end
	end

	// serial slave: sample on scl rise, change data on scl fall
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_r    <= ST_IDLE;
			bit_cnt_r  <= 4'h0;
			shift_r    <= 8'h00;
			tx_r       <= 8'h00;
			ptr_r      <= 8'h00;
			hold_r     <= 8'h00;
			byte_idx_r <= IDX_PTR;
			rw_r       <= 1'b0;
			half_r     <= 1'b0;
			mack_r     <= 1'b0;
			sda_oe_r   <= 1'b0;
		end else if (start_w) begin // repeated start also lands here
			state_r    <= ST_ADDR;
			bit_cnt_r  <= 4'h0;
			byte_idx_r <= IDX_PTR;
			sda_oe_r   <= 1'b0;
		end else if (stop_w) begin
			state_r  <= ST_IDLE;
			sda_oe_r <= 1'b0;
		end else begin
			case (state_r)
				ST_ADDR, ST_RXB: begin
					if (scl_rise_w) begin
						shift_r   <= {shift_r[6:0], sda_in};
						bit_cnt_r <= bit_cnt_r + 4'h1;
					end
					if (scl_fall_w && byte_full_w) begin
						if (state_r == ST_RXB) begin
							state_r  <= ST_ACK_W;
							sda_oe_r <= 1'b1;
							case (byte_idx_r)
								IDX_PTR: begin
									ptr_r      <= shift_r;
									byte_idx_r <= IDX_HI;
								end
								IDX_HI: begin
									hold_r     <= shift_r;
									byte_idx_r <= IDX_LO;
								end
								default: begin // word done, step to next register
									ptr_r      <= ptr_r + 8'h01;
									byte_idx_r <= IDX_HI;
								end
							endcase
						end else if (addr_match_w) begin
							state_r  <= ST_ACK_A;
							rw_r     <= shift_r[0];
							sda_oe_r <= 1'b1;
						end else begin
							state_r <= ST_IDLE;
						end
					end
				end
				ST_ACK_A: begin
					if (scl_fall_w) begin
						bit_cnt_r <= 4'h0;
						if (rw_r) begin
							state_r  <= ST_TXB;
							tx_r     <= rd_word_w[15:8];
							sda_oe_r <= !rd_word_w[15];
							half_r   <= 1'b1;
						end else begin
							state_r  <= ST_RXB;
							sda_oe_r <= 1'b0;
						end
					end
				end
				ST_ACK_W: begin
					if (scl_fall_w) begin
						state_r   <= ST_RXB;
						bit_cnt_r <= 4'h0;
						sda_oe_r  <= 1'b0;
					end
				end
				ST_TXB: begin
					if (scl_rise_w) begin
						bit_cnt_r <= bit_cnt_r + 4'h1;
					end
					if (scl_fall_w) begin
						if (byte_full_w) begin
							state_r  <= ST_ACK_R;
							sda_oe_r <= 1'b0;
						end else begin
							tx_r     <= {tx_r[6:0], 1'b0};
							sda_oe_r <= !tx_r[6];
						end
					end
				end
				ST_ACK_R: begin
					if (scl_rise_w) begin
						mack_r <= !sda_in;
					end
					if (scl_fall_w) begin
						if (mack_r) begin
							state_r   <= ST_TXB;
							bit_cnt_r <= 4'h0;
							tx_r      <= tx_next_w;
							sda_oe_r  <= !tx_next_w[7];
							half_r    <= !half_r;
							if (half_r) begin
								ptr_r <= ptr_r + 8'h01;
							end
						end else begin
							state_r <= ST_IDLE; // master nack ends the read
						end
					end
				end
				default: begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end

	// stored words; writes accepted whenever a word completes, the enable bit only under software control
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			low_r    <= LOW_RST;
			high_r   <= HIGH_RST;
			oe_bit_r <= OE_RST;
			range_r  <= RANGE_DEFAULT;
		end else begin
			if (wr_low_w) begin
				low_r <= wdata_w;
			end
			if (wr_high_w) begin
				high_r <= wdata_w[HIGH_MSB:0];
			end
			if (wr_high_w && oe_sw_ctrl_in) begin
				oe_bit_r <= wdata_w[OE_BIT];
			end
			if (wr_range_w) begin
				range_r <= wdata_w[RANGE_W-1:0];
			end
		end
	end

	// applied offset moves only on a high-word load, so a lone low write waits
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			applied_r <= OFFSET_RST;
			update_r  <= 1'b0;
		end else begin
			update_r <= wr_high_w;
			if (wr_high_w) begin
				applied_r <= {wdata_w[HIGH_MSB:0], low_r};
			end
		end
	end

	// output driver gate: pin decides unless software owns it
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			oe_out_r <= 1'b0;
		end else begin
			oe_out_r <= oe_sw_ctrl_in ? oe_bit_r : oe_pin_in;
		end
	end

	// open drain: only the enable moves, the driven level always stays low
	assign sda_out              = SDA_DRIVE_LEVEL;
	assign sda_oe_out           = sda_oe_r;
	assign output_enable_out    = oe_out_r;
	assign freq_offset_word_out = signed'(applied_r);
	assign freq_update_out      = update_r;
	assign pull_range_out       = range_r; // full scale at range limit

	// checks on the design's own behaviour, all in the clk_in domain
	default clocking chk_clk @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);

	reset_zero_a : assert property ($rose(rst_n_in) |->
		applied_r == OFFSET_RST && !oe_out_r)
		else $error("offset or enable not cleared at reset");
	low_store_a : assert property (wr_low_w |=> low_r == $past(wdata_w))
		else $error("low word not stored");
	low_hold_a : assert property ($changed(applied_r) |-> $past(wr_high_w))
		else $error("offset changed without high word load");
	high_apply_a : assert property (wr_high_w |=> freq_update_out &&
		applied_r == {$past(wdata_w[HIGH_MSB:0]), low_r})
		else $error("high word load not applied");
	sign_bit_a : assert property (freq_update_out |->
		(freq_offset_word_out < 0) == high_r[HIGH_MSB])
		else $error("offset sign wrong");
	oe_hw_hold_a : assert property (!oe_sw_ctrl_in |=> $stable(oe_bit_r))
		else $error("enable bit moved under pin control");
	oe_sw_on_a : assert property (oe_sw_ctrl_in && wr_high_w &&
		wdata_w[OE_BIT] ##1 oe_sw_ctrl_in |=> output_enable_out)
		else $error("software enable not applied");
	ro_zero_a : assert property (ptr_r == REG_HIGH_IDX |->
		rd_word_w[15:RO_LSB] == 5'h00)
		else $error("reserved bits read nonzero");
	range_set_a : assert property (wr_range_w |=>
		pull_range_out == $past(wdata_w[RANGE_W-1:0]))
		else $error("pull range not stored");
	addr_ack_a : assert property (state_r == ST_ACK_A |-> sda_oe_out)
		else $error("address not acknowledged");
	low_part_a : assert property (freq_update_out |->
		freq_offset_word_out[LOW_W-1:0] == low_r)
		else $error("applied low part differs from stored low word");
	low_only_a : assert property (wr_low_w |=>
		$stable(applied_r) && !freq_update_out)
		else $error("low word write moved the applied offset");
	oe_pin_a : assert property (!oe_sw_ctrl_in |=>
		output_enable_out == $past(oe_pin_in))
		else $error("output enable does not follow the pin");
	oe_sw_bit_a : assert property (oe_sw_ctrl_in && wr_high_w |=>
		oe_bit_r == $past(wdata_w[OE_BIT]))
		else $error("software enable bit not stored");
	ack_release_a : assert property (state_r == ST_ACK_W &&
		scl_fall_w |=> !sda_oe_out)
		else $error("data acknowledge not released");
	idle_quiet_a : assert property (state_r == ST_IDLE |-> !sda_oe_out)
		else $error("data line pulled while idle");

	// main scenarios reached
	high_write_c : cover property (wr_low_w ##[1:1000] wr_high_w);
	read_word_c  : cover property (state_r == ST_ACK_R && mack_r && scl_fall_w);
	neg_offset_c : cover property (freq_update_out && freq_offset_word_out < 0);
	pin_write_c  : cover property (!oe_sw_ctrl_in && wr_high_w);
	rep_start_c  : cover property (start_w && state_r != ST_IDLE);

endmodule

// >>> dv/i2c_host_model.sv
`timescale 1ns/1ps
module i2c_host_model #(
	parameter logic [6:0] DEV_ADDR = 7'h55
) (
	input  wire logic clk_in,
	input  wire logic sda_in,
	output logic      scl_out,
	output logic      sda_low_out
);
	logic ack_seen;
	int   nack_cnt = 0;

	// idle bus: both lines released to the pull-ups
	initial begin
		scl_out = 1'b1;
		sda_low_out = 1'b0;
	end

	// one bit: sda moves only while scl is low, 4 clk per phase
	task automatic bit_io(input logic b, output logic r);
		scl_out <= 1'b0;
		repeat (2) @(posedge clk_in);
		sda_low_out <= ~b;
		repeat (2) @(posedge clk_in);
		scl_out <= 1'b1;
		repeat (4) @(posedge clk_in);
		r = sda_in;
	endtask

	// start or repeated start: sda falls while scl high
	task automatic start_c();
		logic r;
		bit_io(1'b1, r);
		sda_low_out <= 1'b1;
		repeat (4) @(posedge clk_in);
	endtask

	// stop: sda rises while scl high
	task automatic stop_c();
		logic r;
		bit_io(1'b0, r);
		sda_low_out <= 1'b0;
		repeat (4) @(posedge clk_in);
	endtask

	// eight bits msb first, then the acknowledge slot
	task automatic byte_io(input logic [7:0] d, input logic last, output logic [7:0] q);
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], q[i]);
		end
		bit_io(last, ack_seen);
	endtask

	task automatic send(input logic [7:0] d);
		logic [7:0] q;
		byte_io(d, 1'b1, q);
		if (ack_seen !== 1'b0) nack_cnt++;
	endtask

	// n words from idx in one burst, then a pause of 2700 clk after the stop
	task automatic wr(input logic [7:0] idx, input logic [15:0] w0, w1, input int n);
		start_c();
		send({DEV_ADDR, 1'b0});
		send(idx);
		send(w0[15:8]);
		send(w0[7:0]);
		if (n == 2) begin
			send(w1[15:8]);
			send(w1[7:0]);
		end
		stop_c();
		repeat (2700) @(posedge clk_in);
	endtask

	// index set by a write, then repeated start and two bytes back
	task automatic rd(input logic [7:0] idx, output logic [15:0] w);
		start_c();
		send({DEV_ADDR, 1'b0});
		send(idx);
		start_c();
		send({DEV_ADDR, 1'b1});
		byte_io(8'hFF, 1'b0, w[15:8]);
		byte_io(8'hFF, 1'b1, w[7:0]);
		stop_c();
	endtask
endmodule

// >>> dv/freq_offset_control_regs_bench.sv
`timescale 1ns/1ps
module freq_offset_control_regs_bench;
	import freq_offset_pkg::*;
	logic                       clk_in = 1'b0;
	logic                       rst_n_in = 1'b0;
	logic                       oe_sw_ctrl_in = 1'b1;
	logic                       oe_pin_in = 1'b0;
	logic                       scl, sda_low, sda_out, sda_oe_out, output_enable_out;
	logic                       freq_update_out;
	logic signed [OFFSET_W-1:0] freq_offset_word_out;
	logic [RANGE_W-1:0]         pull_range_out;
	logic [15:0]                rdata;
	int                         error_cnt = 0;
	int                         checked = 0;
	int                         upd_cnt = 0;
	int                         cycles = 0;
	// pulled-up data line, either party may pull it low
	wire                        sda = ~sda_low & ~(sda_oe_out & ~sda_out);

	always #5 clk_in = ~clk_in;

	freq_offset_control_regs freq_offset_control_regs_inst (
		.clk_in(clk_in), .rst_n_in(rst_n_in), .scl_in(scl), .sda_in(sda),
		.sda_out(sda_out), .sda_oe_out(sda_oe_out), .oe_sw_ctrl_in(oe_sw_ctrl_in),
		.oe_pin_in(oe_pin_in), .output_enable_out(output_enable_out),
		.freq_offset_word_out(freq_offset_word_out), .freq_update_out(freq_update_out),
		.pull_range_out(pull_range_out));
	i2c_host_model #(.DEV_ADDR(7'h55)) i2c_host_model_inst (
		.clk_in(clk_in), .sda_in(sda), .scl_out(scl), .sda_low_out(sda_low));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict();
		$display("counts: %0d compared, %0d mismatched", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// update pulse count and a hang limit well beyond the run's length
	always @(posedge clk_in) begin
		cycles <= cycles + 1;
		if (freq_update_out === 1'b1) upd_cnt <= upd_cnt + 1;
		if (cycles == 60000) begin
			error_cnt++;
			print_verdict();
		end
	end

	initial begin
		repeat (5) @(posedge clk_in);
		rst_n_in <= 1'b1;
		@(posedge clk_in);
		check($unsigned(freq_offset_word_out), 32'h0);
		check(output_enable_out, 1'b0);
		check(pull_range_out, 4'h9);
		i2c_host_model_inst.rd(REG_LOW_IDX, rdata);
		check(rdata, LOW_RST);
		i2c_host_model_inst.rd(REG_HIGH_IDX, rdata);
		check(rdata, 16'h0000);
		$display("test done: reset state");
		// low word alone is stored but not applied
		i2c_host_model_inst.wr(REG_LOW_IDX, 16'h6666, 16'h0000, 1);
		check($unsigned(freq_offset_word_out), 32'h0);
		check(upd_cnt, 0);
		i2c_host_model_inst.rd(REG_LOW_IDX, rdata);
		check(rdata, 16'h6666);
		// high word with read-only bits set applies a negative word
		i2c_host_model_inst.wr(REG_HIGH_IDX, 16'hFFE6, 16'h0000, 1);
		check($unsigned(freq_offset_word_out), 32'h03E66666);
		check(freq_offset_word_out[25], 1'b1);
		check(output_enable_out, 1'b1);
		check(upd_cnt, 1);
		i2c_host_model_inst.rd(REG_HIGH_IDX, rdata);
		check(rdata, 16'h07E6);
		$display("test done: split load");
		// low then high in one burst, enable cleared
		i2c_host_model_inst.wr(REG_LOW_IDX, 16'h1234, 16'h01FF, 2);
		check($unsigned(freq_offset_word_out), 32'h01FF1234);
		check(output_enable_out, 1'b0);
		check(upd_cnt, 2);
		$display("test done: burst");
		// pin control: enable bit writes leave the stored bit alone
		oe_sw_ctrl_in <= 1'b0;
		oe_pin_in <= 1'b1;
		i2c_host_model_inst.wr(REG_HIGH_IDX, 16'h0400, 16'h0000, 1);
		check(output_enable_out, 1'b1);
		i2c_host_model_inst.rd(REG_HIGH_IDX, rdata);
		check(rdata, 16'h0000);
		check($unsigned(freq_offset_word_out), 32'h00001234);
		// pin left high, so a low output can only come from the stored bit
		oe_sw_ctrl_in <= 1'b1;
		repeat (3) @(posedge clk_in);
		check(output_enable_out, 1'b0);
		$display("test done: pin control");
		// pull range field, upper bits read-only
		i2c_host_model_inst.wr(REG_RANGE_IDX, 16'hFFF3, 16'h0000, 1);
		check(pull_range_out, 4'h3);
		i2c_host_model_inst.rd(REG_RANGE_IDX, rdata);
		check(rdata, 16'h0003);
		check(i2c_host_model_inst.nack_cnt, 0);
		// a second reset in mid-run
		rst_n_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		check($unsigned(freq_offset_word_out), 32'h0);
		rst_n_in <= 1'b1;
		repeat (2) @(posedge clk_in);
		check(pull_range_out, 4'h9);
		check(output_enable_out, 1'b0);
		i2c_host_model_inst.rd(REG_LOW_IDX, rdata);
		check(rdata, LOW_RST);
		$display("test done: pull range and reset");
		print_verdict();
	end
endmodule
